// ### hdl/link_loss_fault_flag_watchdog.sv
// Link-loss watchdog: shared timeout counter, fault and power-down periods
`timescale 1ns/1ps

// Function
// - Each bit of the aux pull-up field drives the pull-up of the aux input of the same number, 1 meaning on.
// - The device requests power-down once the upper-nibble period elapses with no valid frame.
// - A power-down period code of zero disables the link-loss power-down.
// - Power-down codes 1 to 13 mean 0.1 s up to 1 hour; 14 and 15 are reserved.
// - The device raises the link-loss fault once the fault period elapses with no valid frame.
// - A fault period code of zero disables the link-loss fault.
// - Fault codes 1 to 13 use the same table from 0.1 s to 1 hour; 14 and 15 are reserved.
// - The timeout is a 24-bit up-counter stepped by a 4 kHz source.
// - One shared counter is compared against both periods.
// - A software write to the counter register loads the running counter.
module link_loss_fault_flag_watchdog
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire wb_req_t wb_req,
  output wb_rsp_t wb_rsp,
  // Link activity
  input wire logic frame_valid,
  // Aux pull-up enables
  output logic [AUX_W-1:0] aux_pullup_en,
  // Link-loss outcomes
  output logic link_loss_fault_flag,
  output logic power_down_req,
  // Interrupt
  output logic irq
);

  // Register state
  logic [AUX_W-1:0] aux_pullup_ff;
  logic [7:0] periods_ff;
  logic [CNT_W-1:0] count_ff;
  logic inhibit_ff;
  logic [IRQ_W-1:0] irq_status_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic fault_hit_prev_ff;
  logic pd_hit_prev_ff;
  logic fault_pulse_ff;
  logic pd_req_ff;
  logic irq_ff;
  logic ack_ff;
  logic [DAT_W-1:0] rdata_ff;

  // Next values
  logic [AUX_W-1:0] nxt_aux_pullup_ff;
  logic [7:0] nxt_periods_ff;
  logic [CNT_W-1:0] nxt_count_ff;
  logic nxt_inhibit_ff;
  logic [IRQ_W-1:0] nxt_irq_status_ff;
  logic [IRQ_W-1:0] nxt_irq_mask_ff;

  // Count-source strobe
  logic tick;

  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // Bus decode; a request is taken once, on the edge before ack
  wire logic req = wb_req.cyc & wb_req.stb & ~ack_ff;
  wire logic wr = req & wb_req.we;
  wire logic [5:0] idx = wb_req.adr[7:2];
  wire logic hit_aux = (idx == ADR_AUX_PULLUP[7:2]);
  wire logic hit_per = (idx == ADR_PERIODS[7:2]);
  wire logic hit_cnt = (idx == ADR_COUNTER[7:2]);
  wire logic hit_ctrl = (idx == ADR_CTRL[7:2]);
  wire logic hit_ist = (idx == ADR_IRQ_STATUS[7:2]);
  wire logic hit_imsk = (idx == ADR_IRQ_MASK[7:2]);
  wire logic hit_state = (idx == ADR_STATE[7:2]);
  wire logic lane0 = wb_req.sel[0];

  wire logic wr_aux = wr & hit_aux & lane0;
  wire logic wr_per = wr & hit_per & lane0;
  wire logic wr_cnt = wr & hit_cnt & (|wb_req.sel[2:0]);
  wire logic wr_ctrl = wr & hit_ctrl & lane0;
  wire logic wr_ist = wr & hit_ist & lane0;
  wire logic wr_imsk = wr & hit_imsk & lane0;

  // Period decode from the two nibbles
  wire logic [PER_W-1:0] pd_code = periods_ff[PD_PER_LSB +: PER_W];
  wire logic [PER_W-1:0] flt_code = periods_ff[FLT_PER_LSB +: PER_W];
  // Reserved codes decode to zero and so act as disabled
  wire logic [CNT_W-1:0] pd_ticks = period_ticks(pd_code);
  wire logic [CNT_W-1:0] flt_ticks = period_ticks(flt_code);

  // Comparisons against the one shared counter
  wire logic pd_hit = (pd_ticks != '0) && (count_ff >= pd_ticks);
  wire logic fault_hit = (flt_ticks != '0) && (count_ff >= flt_ticks);
  wire logic fault_evt = fault_hit & ~fault_hit_prev_ff;
  wire logic pd_evt = pd_hit & ~pd_hit_prev_ff;

  // Byte-lane merge for counter writes
  wire logic [CNT_W-1:0] cnt_wdata = {
    wb_req.sel[2] ? wb_req.dat[23:16] : count_ff[23:16],
    wb_req.sel[1] ? wb_req.dat[15:8] : count_ff[15:8],
    wb_req.sel[0] ? wb_req.dat[7:0] : count_ff[7:0]
  };

  // Counter: software load beats frame clear beats increment
  wire logic cnt_step = tick & (count_ff != CNT_MAX);
  wire logic cnt_clear = frame_valid & ~inhibit_ff;

  always_comb begin
    nxt_count_ff = count_ff;
    if (cnt_step) begin
      nxt_count_ff = count_ff + CNT_W'(1);
    end
    if (cnt_clear) begin
      nxt_count_ff = CNT_RST;
    end
    if (wr_cnt) begin
      nxt_count_ff = cnt_wdata;
    end
  end

  // Plain read/write registers
  assign nxt_aux_pullup_ff = wr_aux ? wb_req.dat[AUX_W-1:0] : aux_pullup_ff;
  assign nxt_periods_ff = wr_per ? wb_req.dat[7:0] : periods_ff;
  assign nxt_inhibit_ff = wr_ctrl ? wb_req.dat[CTRL_INHIBIT_BIT] : inhibit_ff;
  assign nxt_irq_mask_ff = wr_imsk ? wb_req.dat[IRQ_W-1:0] : irq_mask_ff;

  // Sticky status; a new event wins over a same-cycle clear
  wire logic [IRQ_W-1:0] irq_set = {pd_evt, fault_evt};
  wire logic [IRQ_W-1:0] irq_clr = wr_ist ? wb_req.dat[IRQ_W-1:0] : '0;
  assign nxt_irq_status_ff = (irq_status_ff & ~irq_clr) | irq_set;
  wire logic irq_any = |(nxt_irq_status_ff & nxt_irq_mask_ff);

  // Read selection
  wire logic [DAT_W-1:0] rd_mux =
    hit_aux ? DAT_W'(aux_pullup_ff) :
    hit_per ? DAT_W'(periods_ff) :
    hit_cnt ? DAT_W'(count_ff) :
    hit_ctrl ? DAT_W'(inhibit_ff) :
    hit_ist ? DAT_W'(irq_status_ff) :
    hit_imsk ? DAT_W'(irq_mask_ff) :
    hit_state ? DAT_W'({pd_req_ff, fault_hit}) :
    '0;

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_pullup_ff <= AUX_RST;
      periods_ff <= PERIODS_RST;
      count_ff <= CNT_RST;
      inhibit_ff <= 1'b0;
      irq_mask_ff <= IRQ_MASK_RST;
      irq_status_ff <= '0;
    end else begin
      aux_pullup_ff <= nxt_aux_pullup_ff;
      periods_ff <= nxt_periods_ff;
      count_ff <= nxt_count_ff;
      inhibit_ff <= nxt_inhibit_ff;
      irq_mask_ff <= nxt_irq_mask_ff;
      irq_status_ff <= nxt_irq_status_ff;
    end
  end

  // Event edges and outcomes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_hit_prev_ff <= 1'b0;
      pd_hit_prev_ff <= 1'b0;
      fault_pulse_ff <= 1'b0;
      pd_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      fault_hit_prev_ff <= fault_hit;
      pd_hit_prev_ff <= pd_hit;
      fault_pulse_ff <= fault_evt;
      // Held until reset: the shutdown sequencer owns the way out
      pd_req_ff <= pd_req_ff | pd_evt;
      irq_ff <= irq_any;
    end
  end

  // Bus answer: one wait state, ack for exactly one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= req;
      rdata_ff <= req ? rd_mux : '0;
    end
  end

  // Outputs
  assign wb_rsp.ack = ack_ff;
  assign wb_rsp.dat = rdata_ff;
  assign aux_pullup_en = aux_pullup_ff;
  assign link_loss_fault_flag = fault_pulse_ff;
  assign power_down_req = pd_req_ff;
  assign irq = irq_ff;

endmodule // link_loss_fault_flag_watchdog

// ### hdl/tick_divider.sv
// Divides the system clock down to a one-cycle count-source strobe
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned DIV = 50000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strobe
  output logic tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] div_ff;
  logic tick_ff;
  wire logic wrap = (div_ff == W'(DIV - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= wrap ? '0 : div_ff + W'(1);
      tick_ff <= wrap;
    end
  end

  assign tick = tick_ff;

endmodule // tick_divider

// ### hdl/wdog_pkg.sv
// Shared constants, register map and bus carriers for the link-loss watchdog
package wdog_pkg;

  // Bus widths
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // Classic Wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
    logic [3:0] sel;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } wb_rsp_t;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_AUX_PULLUP = 6'h25;
  localparam logic [5:0] IDX_PERIODS = 6'h28;
  localparam logic [5:0] IDX_COUNTER = 6'h29;
  localparam logic [5:0] IDX_CTRL = 6'h30;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h31;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h32;
  localparam logic [5:0] IDX_STATE = 6'h33;

  localparam logic [7:0] ADR_AUX_PULLUP = {IDX_AUX_PULLUP, 2'b00};
  localparam logic [7:0] ADR_PERIODS = {IDX_PERIODS, 2'b00};
  localparam logic [7:0] ADR_COUNTER = {IDX_COUNTER, 2'b00};
  localparam logic [7:0] ADR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] ADR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] ADR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] ADR_STATE = {IDX_STATE, 2'b00};

  // Field layout
  localparam int AUX_W = 8;
  localparam int PER_W = 4;
  localparam int PD_PER_LSB = 4;
  localparam int FLT_PER_LSB = 0;
  localparam int CNT_W = 24;
  localparam int IRQ_W = 2;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_PD_BIT = 1;
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int STATE_FAULT_BIT = 0;
  localparam int STATE_PD_BIT = 1;

  // Reset values
  localparam logic [AUX_W-1:0] AUX_RST = 8'h00;
  localparam logic [7:0] PERIODS_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;

  // Timing: 200 MHz system clock, 4 kHz count source
  localparam longint unsigned CLK_PERIOD_NS = 5;
  localparam longint unsigned TICK_HZ = 4000;
  localparam longint unsigned TICK_PERIOD_NS = 64'd1000000000 / TICK_HZ;
  localparam int unsigned TICK_CYCLES = 32'(TICK_PERIOD_NS / CLK_PERIOD_NS);

  // Period codes in milliseconds; 0, 14 and 15 mean disabled
  localparam longint unsigned PERIOD_MS [16] = '{
    0, 100, 500, 1000, 2000, 5000, 10000, 30000,
    60000, 120000, 300000, 600000, 1800000, 3600000, 0, 0
  };

  function automatic logic [CNT_W-1:0] period_ticks(input logic [3:0] code);
    return CNT_W'(PERIOD_MS[code] * TICK_HZ / 64'd1000);
  endfunction

endpackage

// ### test/host_frame_model.sv
// Host side: sends one valid frame after a chosen gap
`timescale 1ns/1ps
module host_frame_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from bench
  input wire logic go,
  input wire logic [3:0] gap,
  // Frame strobe toward the device
  output logic frame_valid
);
  logic [4:0] wait_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= '0;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= (wait_ff == 5'h01);
      if (go) wait_ff <= {1'b0, gap} + 5'h01;
      else if (wait_ff != '0) wait_ff <= wait_ff - 5'h01;
    end
  end
endmodule // host_frame_model

// ### test/link_loss_fault_flag_watchdog_monitor.sv
// Port checker for the link-loss watchdog
`timescale 1ns/1ps
module wdog_chk
  import wdog_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus and link
  input wire wb_req_t wb_req,
  input wire wb_rsp_t wb_rsp,
  input wire logic frame_valid,
  // Outcomes
  input wire logic [AUX_W-1:0] aux_pullup_en,
  input wire logic link_loss_fault_flag,
  input wire logic power_down_req,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  wire wr = take && wb_req.we;
  property p_ack; take |=> wb_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack1; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_ack1: assert property (p_ack1) else $error("ack held");
  property p_dat0; !wb_rsp.ack |-> wb_rsp.dat == '0; endproperty
  a_dat0: assert property (p_dat0) else $error("data leak");
  property p_auxw;
    wr && wb_req.sel[0] && wb_req.adr == ADR_AUX_PULLUP
      |=> aux_pullup_en == $past(wb_req.dat[7:0]);
  endproperty
  a_auxw: assert property (p_auxw) else $error("aux write");
  property p_auxs; $changed(aux_pullup_en) |-> $past(wr); endproperty
  a_auxs: assert property (p_auxs) else $error("aux drift");
  property p_auxr;
    wb_rsp.ack && $past(take && !wb_req.we && wb_req.adr == ADR_AUX_PULLUP)
      |-> wb_rsp.dat == {24'h0, aux_pullup_en};
  endproperty
  a_auxr: assert property (p_auxr) else $error("aux read");
  property p_flag; link_loss_fault_flag |=> !link_loss_fault_flag; endproperty
  a_flag: assert property (p_flag) else $error("fault long");
  property p_pd; power_down_req |=> power_down_req; endproperty
  a_pd: assert property (p_pd) else $error("power-down lost");
endmodule // wdog_chk
bind link_loss_fault_flag_watchdog wdog_chk u_wdog_chk (.clk(clk), .rst(rst),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .frame_valid(frame_valid),
  .aux_pullup_en(aux_pullup_en), .irq(irq),
  .link_loss_fault_flag(link_loss_fault_flag),
  .power_down_req(power_down_req));

// ### test/link_loss_fault_flag_watchdog_tb_top.sv
// Bench for the link-loss watchdog
`timescale 1ns/1ps
module link_loss_fault_flag_watchdog_tb_top;
  import wdog_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [3:0] gap = 4'h3;
  logic fv, flt, pd, irq;
  logic [7:0] aux;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] q;
  // Ticks per code at 4 kHz
  int tk [13] = '{400, 2000, 4000, 8000, 20000, 40000, 120000, 240000,
    480000, 1200000, 2400000, 7200000, 14400000};
  logic [7:0] radr [5] = '{ADR_AUX_PULLUP, ADR_PERIODS, ADR_IRQ_STATUS,
    ADR_IRQ_MASK, 8'h00};
  logic [7:0] dis [3] = '{8'h00, 8'hfe, 8'hef};
  always #2.5 clk = ~clk;
  // Short tick keeps the long periods simulable
  link_loss_fault_flag_watchdog #(.TICK_DIV(4)) u_link_loss_fault_flag_watchdog (
    .clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .frame_valid(fv),
    .aux_pullup_en(aux), .link_loss_fault_flag(flt),
    .power_down_req(pd), .irq(irq));
  host_frame_model u_host_frame_model (.clk(clk), .rst(rst), .go(go),
    .gap(gap), .frame_valid(fv));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    q = rsp.dat;
    req <= '0;
    chk("ack", 1, {31'h0, rsp.ack});
  endtask
  task automatic ev(bit p, int lo, int hi, logic e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((p ? pd : flt) !== 1'b1 && n < hi);
    chk("event", {31'h0, e}, {31'h0, (p ? pd : flt) === 1'b1 && n >= lo});
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic frame();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    do_reset();
    foreach (radr[i]) begin
      bus(0, radr[i], 0);
      chk("reset_val", 0, q);
    end
    bus(1, ADR_AUX_PULLUP, 32'h5a);
    chk("aux_pins", 32'h5a, {24'h0, aux});
    bus(0, ADR_AUX_PULLUP, 0);
    chk("aux_read", 32'h5a, q);
    bus(1, ADR_CTRL, 1);
    bus(1, ADR_COUNTER, 32'h123456);
    repeat (40) @(posedge clk);
    bus(0, ADR_COUNTER, 0);
    chk("count", 1, {31'h0, q - 32'h123456 inside {[10:12]}});
    for (int s = 0; s < 2; s++)
      for (int c = 1; c < 14; c++) begin
        do_reset();
        bus(1, ADR_CTRL, 1);
        bus(1, ADR_PERIODS, 32'(s ? c << 4 : c));
        bus(1, ADR_COUNTER, tk[c-1] - 3);
        ev(s, 4, 20, 1);
      end
    do_reset();
    foreach (dis[i]) begin
      bus(1, ADR_PERIODS, {24'h0, dis[i]});
      bus(1, ADR_COUNTER, 32'hfffff0);
      ev(0, 0, 40, 0);
      ev(1, 0, 5, 0);
    end
    // Counter first: it sits a few ticks below CNT_MAX, enabling periods would fire both
    bus(1, ADR_COUNTER, 32'd390);
    bus(1, ADR_PERIODS, 32'h21);
    frame();
    ev(0, 0, 60, 0);
    bus(1, ADR_CTRL, 1);
    bus(1, ADR_COUNTER, 32'd390);
    frame();
    ev(0, 20, 60, 1);
    chk("irq_masked", 0, {31'h0, irq});
    bus(0, ADR_IRQ_STATUS, 0);
    chk("status", 1, q);
    bus(0, ADR_STATE, 0);
    chk("state", 1, q);
    bus(1, ADR_IRQ_MASK, 1);
    @(posedge clk);
    chk("irq_on", 1, {31'h0, irq});
    bus(1, ADR_IRQ_STATUS, 1);
    @(posedge clk);
    chk("irq_off", 0, {31'h0, irq});
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule // link_loss_fault_flag_watchdog_tb_top
